// File: shared/ufsb_pkg.sv
// constants and types for the half-duplex uart channel
//
// Function
// - buffer write in transmit mode sets full; load clears it
// - writing one clears full flag
// - full flag reads zero in receive mode
// - transmit-active set while shifting out
// - receive-active set while shifting in
// - unread data survives disable, still overruns
// - false start bit returns to hunting
// - frame is start, data, parity, stop
// - five to eight data bits
// - parity none, even, odd, one, zero
// - one or two transmit stop bits
// - lsb or msb first both ways
// - line polarity positive or inverted
// - rate generator base clock is selectable
// - bit period is count+1+frac/8 base clocks
// - bad stop bit sets framing error
// - frame over unread data sets overrun
// - parity mismatch sets parity error
// - receiver samples at bit middle
package ufsb_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MODE = 8'h04;
	localparam logic [7:0] OFF_BRT = 8'h08;
	localparam logic [7:0] OFF_BRC = 8'h0C;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_BUF = 8'h14;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_TX_BIT = 1;
	localparam int MODE_LEN_LSB = 0;
	localparam int MODE_PAR_LSB = 2;
	localparam int MODE_STOP2_BIT = 5;
	localparam int MODE_MSB_BIT = 6;
	localparam int MODE_NEG_BIT = 7;
	localparam int MODE_SEL_LSB = 8;
	localparam int STAT_FER_BIT = 0;
	localparam int STAT_OER_BIT = 1;
	localparam int STAT_PER_BIT = 2;
	localparam int STAT_FUL_BIT = 3;
	localparam int STAT_TXF_BIT = 4;
	localparam int STAT_RXF_BIT = 5;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [9:0] MODE_RST = 10'h000;
	localparam logic [15:0] BRT_RST = 16'hFFFF;
	localparam logic [2:0] BRC_RST = 3'h0;
	localparam logic [3:0] FRAC_DEN = 4'h8;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_ONE, PAR_ZERO} ufsb_par_t;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ufsb_state_t;
endpackage

// File: shared/ufsb_baud_if.sv
// link between the frame engine and the bit-rate generator
`timescale 1ns/1ps
`default_nettype none
interface ufsb_baud_if;
	logic run;
	logic restart;
	logic [15:0] cnt;
	logic [2:0] frac;
	logic [1:0] sel;
	logic mid;
	logic bit_end;
	modport gen (input run, input restart, input cnt, input frac, input sel,
		output mid, output bit_end);
	modport user (output run, output restart, output cnt, output frac, output sel,
		input mid, input bit_end);
endinterface
`default_nettype wire

// File: rtl/ufsb_baud_gen.sv
// fractional bit-rate generator with selectable base clock
`timescale 1ns/1ps
`default_nettype none
module ufsb_baud_gen import ufsb_pkg::*; #(
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic rstn,
	ufsb_baud_if.gen bus
);
	if (CNT_W != 16) begin : g_chk
		$error("ufsb_baud_gen: CNT_W must be 16");
	end

	logic [2:0] presc_reg;
	logic [CNT_W:0] tick_cnt_reg;
	logic [2:0] acc_reg;
	logic base_tick;
	logic [3:0] acc_sum;
	logic [CNT_W:0] last_cnt;

	// base clock is clk divided by 1, 2, 4 or 8
	// restart realigns the divider so the first bit is not cut short
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			presc_reg <= 3'h0;
		end else if (bus.restart) begin
			presc_reg <= 3'h0;
		end else begin
			presc_reg <= presc_reg + 3'h1;
		end
	end

	always_comb begin
		case (bus.sel)
			2'h0: base_tick = 1'b1;
			2'h1: base_tick = presc_reg[0];
			2'h2: base_tick = &presc_reg[1:0];
			default: base_tick = &presc_reg;
		endcase
	end

	// an extra base tick is added whenever the fraction accumulator carries
	assign acc_sum = {1'b0, acc_reg} + {1'b0, bus.frac};
	assign last_cnt = {1'b0, bus.cnt} + {{CNT_W{1'b0}}, acc_sum >= FRAC_DEN};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_reg <= '0;
			acc_reg <= 3'h0;
		end else if (bus.restart || !bus.run) begin
			tick_cnt_reg <= '0;
			acc_reg <= 3'h0;
		end else if (base_tick) begin
			if (tick_cnt_reg == last_cnt) begin
				tick_cnt_reg <= '0;
				acc_reg <= acc_sum[2:0];
			end else begin
				tick_cnt_reg <= tick_cnt_reg + 1'b1;
			end
		end
	end

	assign bus.bit_end = bus.run && !bus.restart && base_tick && (tick_cnt_reg == last_cnt);
	assign bus.mid = bus.run && !bus.restart && base_tick
		&& (tick_cnt_reg == {2'b00, bus.cnt[CNT_W-1:1]});
endmodule
`default_nettype wire

// File: rtl/ufsb_top.sv
// half-duplex uart channel with apb registers
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ufsb_top import ufsb_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd,
	output logic rx_done,
	output logic tx_done
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [1:0] ctrl_reg;
	logic [9:0] mode_reg;
	logic [15:0] brt_reg;
	logic [2:0] brc_reg;
	logic ful_reg, fer_reg, oer_reg, per_reg, unread_reg;
	logic [7:0] txbuf_reg, rxbuf_reg, shift_reg;
	logic [2:0] bit_cnt_reg;
	logic stop_cnt_reg, par_bit_reg, txd_reg, rx_done_reg, tx_done_reg;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg;
	ufsb_state_t state_reg;

	logic en, tx_mode, neg, msb, stop2, has_par, rx_line, adv, start_go, tx_load;
	logic frame_end, rx_end, tx_end, acc_edge, wr, rd, stat_wr, buf_wr, buf_rd, tx_level;
	logic [1:0] len_code;
	logic [2:0] last_idx, idx;
	logic [7:0] status_rd;
	ufsb_par_t par_kind;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] len_mask(input logic [7:0] d, input logic [1:0] lc);
		len_mask = d & (8'hFF >> (2'h3 - lc));
	endfunction

	function automatic logic par_calc(input logic [7:0] d, input logic [1:0] lc,
		input ufsb_par_t k);
		case (k)
			PAR_EVEN: par_calc = ^len_mask(d, lc);
			PAR_ODD: par_calc = ~^len_mask(d, lc);
			PAR_ONE: par_calc = 1'b1;
			default: par_calc = 1'b0;
		endcase
	endfunction

	assign en = ctrl_reg[CTRL_EN_BIT];
	assign tx_mode = ctrl_reg[CTRL_TX_BIT];
	assign len_code = mode_reg[MODE_LEN_LSB +: 2];
	assign par_kind = ufsb_par_t'(mode_reg[MODE_PAR_LSB +: 3]);
	assign has_par = (par_kind == PAR_EVEN) || (par_kind == PAR_ODD)
		|| (par_kind == PAR_ONE) || (par_kind == PAR_ZERO);
	assign stop2 = mode_reg[MODE_STOP2_BIT];
	assign msb = mode_reg[MODE_MSB_BIT];
	assign neg = mode_reg[MODE_NEG_BIT];
	assign last_idx = {1'b0, len_code} + 3'h4;
	assign idx = msb ? (last_idx - bit_cnt_reg) : bit_cnt_reg;
	assign rx_line = rxd ^ neg;

	// ----------------------------------------------------------------
	// rate generator
	// ----------------------------------------------------------------
	ufsb_baud_if bif();
	assign bif.run = (state_reg != ST_IDLE);
	assign bif.restart = start_go;
	assign bif.cnt = brt_reg;
	assign bif.frac = brc_reg;
	assign bif.sel = mode_reg[MODE_SEL_LSB +: 2];

	ufsb_baud_gen #(.CNT_W(16)) u_baud (
		.clk(clk),
		.rstn(rstn),
		.bus(bif.gen)
	);

	// transmit steps on bit ends, receive on bit middles
	assign adv = tx_mode ? bif.bit_end : bif.mid;
	assign start_go = en && (state_reg == ST_IDLE)
		&& (tx_mode ? ful_reg : !rx_line);
	assign tx_load = start_go && tx_mode;
	assign frame_end = en && (state_reg == ST_STOP) && adv
		&& !(tx_mode && stop2 && !stop_cnt_reg);
	assign rx_end = frame_end && !tx_mode;
	assign tx_end = frame_end && tx_mode;

	// ----------------------------------------------------------------
	// frame engine
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			stop_cnt_reg <= 1'b0;
			par_bit_reg <= 1'b0;
		end else if (!en) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start_go) begin
						state_reg <= ST_START;
						if (tx_mode) begin
							shift_reg <= txbuf_reg;
						end
						bit_cnt_reg <= 3'h0;
						stop_cnt_reg <= 1'b0;
					end
				end
				ST_START: begin
					if (adv) begin
						// a glitch shorter than half a bit is not a frame
						state_reg <= (!tx_mode && rx_line) ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA: begin
					if (adv) begin
						if (!tx_mode) begin
							shift_reg[idx] <= rx_line;
						end
						if (bit_cnt_reg == last_idx) begin
							state_reg <= has_par ? ST_PAR : ST_STOP;
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 3'h1;
						end
					end
				end
				ST_PAR: begin
					if (adv) begin
						par_bit_reg <= rx_line;
						state_reg <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (adv) begin
						if (tx_mode && stop2 && !stop_cnt_reg) begin
							stop_cnt_reg <= 1'b1;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_comb begin
		case (state_reg)
			ST_START: tx_level = 1'b0;
			ST_DATA: tx_level = shift_reg[idx];
			ST_PAR: tx_level = par_calc(shift_reg, len_code, par_kind);
			default: tx_level = 1'b1;
		endcase
		if (!tx_mode) begin
			tx_level = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txd_reg <= 1'b1;
			rx_done_reg <= 1'b0;
			tx_done_reg <= 1'b0;
		end else begin
			txd_reg <= tx_level ^ neg;
			rx_done_reg <= rx_end;
			tx_done_reg <= tx_end;
		end
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	assign acc_edge = psel && penable && pready_reg;
	assign wr = acc_edge && pwrite;
	assign rd = acc_edge && !pwrite;
	assign stat_wr = wr && (paddr == OFF_STAT);
	assign buf_wr = wr && (paddr == OFF_BUF);
	assign buf_rd = rd && (paddr == OFF_BUF);

	// error flags read zero while sending, full flag while receiving
	assign status_rd = {2'b00,
		!tx_mode && (state_reg != ST_IDLE),
		tx_mode && (state_reg != ST_IDLE),
		tx_mode && ful_reg,
		!tx_mode && per_reg,
		!tx_mode && oer_reg,
		!tx_mode && fer_reg};
	logic [7:0] status_val;
	assign status_val = status_rd;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= psel && !penable;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			if (psel && !penable) begin
				case (paddr)
					OFF_CTRL: prdata_reg <= {30'h0, ctrl_reg};
					OFF_MODE: prdata_reg <= {22'h0, mode_reg};
					OFF_BRT: prdata_reg <= {16'h0, brt_reg};
					OFF_BRC: prdata_reg <= {29'h0, brc_reg};
					OFF_STAT: prdata_reg <= {24'h0, status_val};
					OFF_BUF: prdata_reg <= {24'h0, rxbuf_reg};
					default: pslverr_reg <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= CTRL_RST;
			mode_reg <= MODE_RST;
			brt_reg <= BRT_RST;
			brc_reg <= BRC_RST;
			txbuf_reg <= 8'h00;
		end else if (wr) begin
			case (paddr)
				OFF_CTRL: ctrl_reg <= pwdata[1:0];
				OFF_MODE: mode_reg <= pwdata[9:0];
				OFF_BRT: brt_reg <= pwdata[15:0];
				OFF_BRC: brc_reg <= pwdata[2:0];
				OFF_BUF: txbuf_reg <= pwdata[7:0];
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status flags: a hardware set always beats a software clear
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ful_reg <= 1'b0;
		end else if (buf_wr && tx_mode) begin
			ful_reg <= 1'b1;
		end else if (tx_load || !tx_mode) begin
			ful_reg <= 1'b0;
		end else if (stat_wr && pwdata[STAT_FUL_BIT]) begin
			ful_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fer_reg <= 1'b0;
			per_reg <= 1'b0;
			oer_reg <= 1'b0;
		end else begin
			if (rx_end && !rx_line) begin
				fer_reg <= 1'b1;
			end else if (stat_wr && pwdata[STAT_FER_BIT]) begin
				fer_reg <= 1'b0;
			end
			if (rx_end && has_par && (par_bit_reg != par_calc(shift_reg, len_code, par_kind))) begin
				per_reg <= 1'b1;
			end else if (stat_wr && pwdata[STAT_PER_BIT]) begin
				per_reg <= 1'b0;
			end
			if (rx_end && unread_reg) begin
				oer_reg <= 1'b1;
			end else if (stat_wr && pwdata[STAT_OER_BIT]) begin
				oer_reg <= 1'b0;
			end
		end
	end

	// unread marker is kept across disable so a stale byte still overruns
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			unread_reg <= 1'b0;
			rxbuf_reg <= 8'h00;
		end else if (rx_end) begin
			unread_reg <= 1'b1;
			rxbuf_reg <= len_mask(shift_reg, len_code);
		end else if (buf_rd) begin
			unread_reg <= 1'b0;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign txd = txd_reg;
	assign rx_done = rx_done_reg;
	assign tx_done = tx_done_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	a_ful_set_wr: assert property (buf_wr && tx_mode |=> ful_reg)
		else $error("full flag not set by buffer write");
	a_ful_w1c: assert property (stat_wr && pwdata[STAT_FUL_BIT] && !buf_wr |=> !ful_reg)
		else $error("full flag not cleared by write of one");
	a_ful_rx_zero: assert property (!tx_mode && !$past(tx_mode) |-> !ful_reg)
		else $error("full flag visible in receive mode");
	a_txf_load: assert property (tx_load && !buf_wr |=> status_val[STAT_TXF_BIT] && !ful_reg)
		else $error("transmit active not shown after load");
	a_rxf_data: assert property (state_reg == ST_DATA && !tx_mode |-> status_val[STAT_RXF_BIT])
		else $error("receive active not shown");
	a_rx_abort: assert property (en && !tx_mode && state_reg == ST_START && adv && rx_line
		|=> state_reg == ST_IDLE)
		else $error("false start bit not abandoned");
	a_start_level: assert property (tx_load && !$past(tx_load) |-> ##2 txd_reg == neg)
		else $error("start bit level wrong");
	a_oer_set: assert property (rx_end && unread_reg |=> oer_reg && rx_done_reg)
		else $error("overrun not flagged");
	a_fer_set: assert property (rx_end && !rx_line |=> fer_reg && rx_done_reg)
		else $error("framing error not flagged");
	a_done_pulse: assert property (rx_done_reg |=> !rx_done_reg)
		else $error("receive done longer than one cycle");

	c_tx_frame: cover property (tx_load ##[1:1000] tx_done_reg);
	c_rx_frame: cover property (rx_done_reg);
	c_rx_abort: cover property (state_reg == ST_START && !tx_mode ##1 state_reg == ST_IDLE);
endmodule
`default_nettype wire

// File: sim/ufsb_remote.sv
// far-side serial partner: sends frames on rxd, captures frames from txd
`timescale 1ns/1ps
`default_nettype none
module ufsb_remote (
	input wire logic clk,
	input wire logic txd,
	output logic rxd,
	input wire logic watch,
	input wire logic neg,
	input wire logic [3:0] nb,
	output logic got,
	output logic [11:0] frame
);
	localparam int BIT = 4;
	logic busy;
	logic lvl;
	logic [11:0] f;
	initial begin
		busy = 1'b0;
		lvl = 1'b1;
		got = 1'b0;
		frame = 12'h000;
	end
	// idle follows polarity so a mode change never fakes a start
	assign rxd = busy ? lvl : ~neg;
	task automatic send(input logic [11:0] lv, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			busy <= 1'b1;
			lvl <= lv[i];
			repeat (BIT - 1) @(posedge clk);
		end
		@(posedge clk);
		busy <= 1'b0;
	endtask
	// start level for one clock only, well short of mid bit
	task automatic blip;
		@(posedge clk);
		busy <= 1'b1;
		lvl <= neg;
		@(posedge clk);
		busy <= 1'b0;
	endtask
	always begin
		@(posedge clk);
		if (watch === 1'b1 && txd === neg) begin
			f = 12'h000;
			repeat (BIT / 2) @(posedge clk);
			for (int i = 0; i < nb; i++) begin
				f[i] = txd;
				if (i < nb - 1) repeat (BIT) @(posedge clk);
			end
			frame <= f;
			got <= 1'b1;
			@(posedge clk);
			got <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: sim/uart_frame_status_baud_test.sv
// self-checking bench for the half-duplex uart channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end
module uart_frame_status_baud_test import ufsb_pkg::*;;
	localparam logic [9:0] MODES [5] = '{10'h003, 10'h064, 10'h089, 10'h02E, 10'h0D3};
	localparam logic [4:0] BAUD [4] = '{5'h04, 5'h08, 5'h12, 5'h19};
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, rxd, txd, rx_done, tx_done;
	logic watch, neg, got;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] nb;
	logic [11:0] frame, fh;
	logic [64:0] rh;
	logic [64:0] rq[$];
	logic [11:0] fq[$];
	int err_total, checked, seed, nrx, ntx;
	ufsb_top DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxd(rxd), .txd(txd), .rx_done(rx_done), .tx_done(tx_done));
	ufsb_remote remote (.clk(clk), .txd(txd), .rxd(rxd), .watch(watch), .neg(neg), .nb(nb),
		.got(got), .frame(frame));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task complete_run;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task stop_run;
		err_total++;
		complete_run;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [64:0] e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr) rq.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
		if (n >= 20) stop_run;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 65'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, 32'hFFFFFFFF, e});
	endtask
	task automatic wt(input logic tx);
		int n;
		n = 0;
		do begin @(posedge clk); n++; end while ((tx ? tx_done : rx_done) !== 1'b1 && n < 3000);
		if (n >= 3000) stop_run;
	endtask
	task automatic rx1(input logic [11:0] f, input int n);
		fork
			remote.send(f, n);
			wt(1'b0);
		join
		repeat (4) @(posedge clk);
	endtask
	function automatic logic [11:0] mkf(input logic [7:0] d, input logic [9:0] m, output int n);
		int len;
		logic p;
		logic [11:0] f;
		len = m[1:0] + 5;
		f = 12'h000;
		p = 1'b0;
		n = 1;
		for (int i = 0; i < len; i++) begin
			f[n] = m[6] ? d[len - 1 - i] : d[i];
			p = p ^ d[i];
			n++;
		end
		if (m[4:2] inside {[3'h1:3'h4]}) begin
			f[n] = (m[4:2] == 3'h1) ? p : (m[4:2] == 3'h2) ? ~p : (m[4:2] == 3'h3);
			n++;
		end
		f[n] = 1'b1;
		if (m[5]) begin
			n++;
			f[n] = 1'b1;
		end
		n++;
		return m[7] ? f ^ ((12'h001 << n) - 12'h001) : f;
	endfunction
	// ----------------------------------------------------------------
	// result watcher
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rx_done === 1'b1) nrx++;
		if (tx_done === 1'b1) ntx++;
		if (got === 1'b1) begin
			`CHK(fq.size() > 0, 1'b1)
			fh = fq.pop_front();
			`CHK(frame, fh)
		end
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			`CHK(rq.size() > 0, 1'b1)
			rh = rq.pop_front();
			`CHK({pslverr, prdata} & {1'b1, rh[63:32]}, {rh[64], rh[31:0] & rh[63:32]})
		end
	end
	initial begin
		#5000000;
		stop_run;
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int n, c, e8, t;
		logic [9:0] m;
		logic [7:0] d, d2;
		logic [11:0] f;
		{rstn, psel, penable, pwrite, watch, neg, paddr, pwdata} = '0;
		nb = 4'hC;
		seed = 848;
		{err_total, checked, nrx, ntx} = '0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(OFF_CTRL, 32'h0);
		rd(OFF_MODE, 32'h0);
		rd(OFF_BRT, 32'h0000FFFF);
		rd(OFF_BRC, 32'h0);
		rd(OFF_STAT, 32'h0);
		apb(1'b0, 8'h18, 32'h0, {1'b1, 32'hFFFFFFFF, 32'h0});
		wr(OFF_BRT, 32'h3);
		$display("test reset done");
		for (int r = 0; r < 5; r++) begin
			m = MODES[r];
			wr(OFF_CTRL, 32'h0);
			wr(OFF_MODE, {22'h0, m});
			neg <= m[7];
			wr(OFF_CTRL, 32'h3);
			watch <= 1'b1;
			d = $random(seed);
			d2 = $random(seed);
			c = ntx;
			fq.push_back(mkf(d, m, n));
			fq.push_back(mkf(d2, m, n));
			nb <= n[3:0];
			wr(OFF_BUF, d);
			wr(OFF_BUF, d2);
			rd(OFF_STAT, 32'h18);
			wr(OFF_STAT, 32'h0);
			rd(OFF_STAT, 32'h18);
			wt(1'b1);
			wt(1'b1);
			repeat (4) @(posedge clk);
			`CHK(ntx - c, 2)
			rd(OFF_STAT, 32'h0);
			watch <= 1'b0;
			wr(OFF_CTRL, 32'h1);
			rx1(mkf(d, m, n), n);
			rd(OFF_STAT, 32'h0);
			rd(OFF_BUF, d & (8'hFF >> (3 - m[1:0])));
		end
		$display("test formats done");
		wr(OFF_CTRL, 32'h0);
		wr(OFF_MODE, 32'h7);
		neg <= 1'b0;
		wr(OFF_CTRL, 32'h1);
		wr(OFF_BUF, 32'h55);
		rd(OFF_STAT, 32'h0);
		d = $random(seed);
		f = mkf(d, 10'h007, n);
		rx1(f ^ 12'h200, n);
		rd(OFF_STAT, 32'h4);
		wr(OFF_STAT, 32'h0);
		rd(OFF_STAT, 32'h4);
		wr(OFF_STAT, 32'h7);
		rd(OFF_STAT, 32'h0);
		apb(1'b0, OFF_BUF, 32'h0, 65'h0);
		rx1(f & 12'hBFF, n);
		rd(OFF_STAT, 32'h1);
		wr(OFF_STAT, 32'h7);
		apb(1'b0, OFF_BUF, 32'h0, 65'h0);
		rx1(f, n);
		rx1(f, n);
		rd(OFF_STAT, 32'h2);
		wr(OFF_STAT, 32'h7);
		apb(1'b0, OFF_BUF, 32'h0, 65'h0);
		rx1(f, n);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CTRL, 32'h1);
		rx1(f, n);
		rd(OFF_STAT, 32'h2);
		wr(OFF_STAT, 32'h7);
		apb(1'b0, OFF_BUF, 32'h0, 65'h0);
		c = nrx;
		remote.blip;
		repeat (40) @(posedge clk);
		`CHK(nrx - c, 0)
		rd(OFF_STAT, 32'h0);
		rx1(f, n);
		rd(OFF_BUF, d);
		$display("test errors done");
		wr(OFF_CTRL, 32'h2);
		wr(OFF_BUF, 32'h5A);
		rd(OFF_STAT, 32'h8);
		wr(OFF_STAT, 32'h8);
		rd(OFF_STAT, 32'h0);
		wr(OFF_CTRL, 32'h0);
		for (int r = 0; r < 4; r++) begin
			wr(OFF_MODE, {22'h0, BAUD[r][4:3], 8'h03});
			wr(OFF_BRC, {29'h0, BAUD[r][2:0]});
			wr(OFF_CTRL, 32'h3);
			wr(OFF_BUF, 32'h5A);
			n = 0;
			while (txd !== 1'b0 && n < 400) begin @(posedge clk); n++; end
			c = 0;
			while (tx_done !== 1'b1 && c < 4000) begin @(posedge clk); c++; end
			if (n >= 400 || c >= 4000) stop_run;
			e8 = 10 * (32 + BAUD[r][2:0]) * (1 << BAUD[r][4:3]);
			t = 8 * ((1 << BAUD[r][4:3]) + 1);
			`CHK((c * 8 <= e8 + t) && (c * 8 + t >= e8), 1'b1)
			wr(OFF_CTRL, 32'h0);
		end
		$display("test baud done");
		complete_run;
	end
endmodule
`default_nettype wire
